/* File: hw/cccr_pkg.sv */
/*
  constants for the channel configuration and calibration register bank.
  assumes an ahb-lite slave with 32-bit data and printed offsets as word indices.
*/
`default_nettype none
package cccr_pkg;
  // ==========================================================
  // register indices, byte address is four times the index
  localparam logic [7:0] CCCR_IDX_CONFIG = 8'h0e;
  localparam logic [7:0] CCCR_IDX_OFS_HI = 8'h0f;
  localparam logic [7:0] CCCR_IDX_OFS_LO = 8'h10;
  localparam logic [7:0] CCCR_IDX_GAIN_HI = 8'h11;
  localparam logic [7:0] CCCR_IDX_GAIN_LO = 8'h12;
  // ==========================================================
  // reset values
  localparam logic [15:0] CCCR_RST_CONFIG = 16'h0000;
  localparam logic [15:0] CCCR_RST_OFS_HI = 16'h0000;
  localparam logic [15:0] CCCR_RST_OFS_LO = 16'h0000;
  localparam logic [15:0] CCCR_RST_GAIN_HI = 16'h8000;
  localparam logic [15:0] CCCR_RST_GAIN_LO = 16'h0000;
  // ==========================================================
  // writable bit masks
  localparam logic [15:0] CCCR_MASK_CONFIG = 16'hffc7;
  localparam logic [15:0] CCCR_MASK_FULL = 16'hffff;
  localparam logic [15:0] CCCR_MASK_LOW = 16'hff00;
  // ==========================================================
  // field positions
  localparam int CCCR_PHASE_MSB = 15;
  localparam int CCCR_PHASE_LSB = 6;
  localparam int CCCR_BYPASS_BIT = 2;
  localparam int CCCR_SEL_MSB = 1;
  localparam int CCCR_SEL_LSB = 0;
  localparam int CCCR_RSV_MSB = 5;
  localparam int CCCR_RSV_LSB = 3;
  localparam int CCCR_IDX_MSB = 9;
  localparam int CCCR_IDX_LSB = 2;
  localparam int CCCR_LOW_MSB = 15;
  localparam int CCCR_LOW_LSB = 8;
  localparam int CCCR_GAIN_FRAC = 23;
  // ==========================================================
  // input selector codes and ahb transfer codes
  typedef enum logic [1:0] {
    CCCR_SRC_NORMAL = 2'h0,
    CCCR_SRC_SHORTED = 2'h1,
    CCCR_SRC_TEST_POS = 2'h2,
    CCCR_SRC_TEST_NEG = 2'h3
  } cccr_src_e;
  localparam logic [1:0] CCCR_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] CCCR_HSIZE_WORD = 3'h2;
endpackage
`default_nettype wire

/* File: hw/cccr_regs.sv */
/*
  channel configuration and calibration register bank with ahb-lite slave,
  plus the datapath applying offset and gain to a conversion result.
  assumes a single master; every transfer is answered okay with no wait state.
*/
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module cccr_regs #(
  parameter int SAMPLE_WIDTH = 24
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic signed [SAMPLE_WIDTH-1:0] sample_in,
  input wire logic sample_valid_in,
  output logic signed [SAMPLE_WIDTH-1:0] sample_out,
  output logic sample_valid_out,
  output logic signed [9:0] phase_delay_field_out,
  output logic dc_filter_bypass_out,
  output logic [1:0] input_source_select_out,
  output logic signed [23:0] offset_cal_out,
  output logic [23:0] gain_cal_out
);
  // ==========================================================
  // address phase capture
  logic wr_pend_reg, wr_pend_next;
  logic [7:0] wr_idx_reg, wr_idx_next;
  logic [15:0] cfg_reg, cfg_next;
  logic [15:0] ofs_hi_reg, ofs_hi_next;
  logic [15:0] ofs_lo_reg, ofs_lo_next;
  logic [15:0] gain_hi_reg, gain_hi_next;
  logic [15:0] gain_lo_reg, gain_lo_next;
  logic [31:0] rdata_reg, rdata_next;
  logic addr_ok;
  logic [7:0] addr_idx;
  logic [15:0] rd_word;

  assign addr_ok = hsel_in && hready_in && (htrans_in == cccr_pkg::CCCR_HTRANS_NONSEQ);
  assign addr_idx = haddr_in[cccr_pkg::CCCR_IDX_MSB:cccr_pkg::CCCR_IDX_LSB];

  always_comb begin
    unique case (addr_idx)
      cccr_pkg::CCCR_IDX_CONFIG: rd_word = cfg_reg & cccr_pkg::CCCR_MASK_CONFIG;
      cccr_pkg::CCCR_IDX_OFS_HI: rd_word = ofs_hi_reg;
      cccr_pkg::CCCR_IDX_OFS_LO: rd_word = ofs_lo_reg & cccr_pkg::CCCR_MASK_LOW;
      cccr_pkg::CCCR_IDX_GAIN_HI: rd_word = gain_hi_reg;
      cccr_pkg::CCCR_IDX_GAIN_LO: rd_word = gain_lo_reg & cccr_pkg::CCCR_MASK_LOW;
      default: rd_word = 16'h0000;
    endcase
  end

  always_comb begin
    wr_pend_next = addr_ok && hwrite_in && (hsize_in == cccr_pkg::CCCR_HSIZE_WORD);
    wr_idx_next = addr_ok ? addr_idx : wr_idx_reg;
    rdata_next = (addr_ok && !hwrite_in) ? {16'h0000, rd_word} : 32'h0000_0000;
    cfg_next = cfg_reg;
    ofs_hi_next = ofs_hi_reg;
    ofs_lo_next = ofs_lo_reg;
    gain_hi_next = gain_hi_reg;
    gain_lo_next = gain_lo_reg;
    if (wr_pend_reg) begin
      unique case (wr_idx_reg)
        cccr_pkg::CCCR_IDX_CONFIG: cfg_next = hwdata_in[15:0] & cccr_pkg::CCCR_MASK_CONFIG;
        cccr_pkg::CCCR_IDX_OFS_HI: ofs_hi_next = hwdata_in[15:0];
        cccr_pkg::CCCR_IDX_OFS_LO: ofs_lo_next = hwdata_in[15:0] & cccr_pkg::CCCR_MASK_LOW;
        cccr_pkg::CCCR_IDX_GAIN_HI: gain_hi_next = hwdata_in[15:0];
        cccr_pkg::CCCR_IDX_GAIN_LO: gain_lo_next = hwdata_in[15:0] & cccr_pkg::CCCR_MASK_LOW;
        default: cfg_next = cfg_reg;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 8'h00;
      rdata_reg <= 32'h0000_0000;
      cfg_reg <= cccr_pkg::CCCR_RST_CONFIG;
      ofs_hi_reg <= cccr_pkg::CCCR_RST_OFS_HI;
      ofs_lo_reg <= cccr_pkg::CCCR_RST_OFS_LO;
      gain_hi_reg <= cccr_pkg::CCCR_RST_GAIN_HI;
      gain_lo_reg <= cccr_pkg::CCCR_RST_GAIN_LO;
    end else begin
      wr_pend_reg <= wr_pend_next;
      wr_idx_reg <= wr_idx_next;
      rdata_reg <= rdata_next;
      cfg_reg <= cfg_next;
      ofs_hi_reg <= ofs_hi_next;
      ofs_lo_reg <= ofs_lo_next;
      gain_hi_reg <= gain_hi_next;
      gain_lo_reg <= gain_lo_next;
    end
  end

  assign hrdata_out = rdata_reg;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  // ==========================================================
  // field outputs
  assign phase_delay_field_out = cfg_reg[cccr_pkg::CCCR_PHASE_MSB:cccr_pkg::CCCR_PHASE_LSB];
  assign dc_filter_bypass_out = cfg_reg[cccr_pkg::CCCR_BYPASS_BIT];
  assign input_source_select_out = cfg_reg[cccr_pkg::CCCR_SEL_MSB:cccr_pkg::CCCR_SEL_LSB];
  assign offset_cal_out = {ofs_hi_reg,
    ofs_lo_reg[cccr_pkg::CCCR_LOW_MSB:cccr_pkg::CCCR_LOW_LSB]};
  assign gain_cal_out = {gain_hi_reg,
    gain_lo_reg[cccr_pkg::CCCR_LOW_MSB:cccr_pkg::CCCR_LOW_LSB]};
  // ==========================================================
  // correction datapath: gain is 1.23 unsigned, result saturates
  logic signed [SAMPLE_WIDTH-1:0] res_reg, res_next;
  logic vld_reg, vld_next;
  logic signed [SAMPLE_WIDTH+1:0] summed;
  logic signed [SAMPLE_WIDTH+1:0] sample_ext;
  logic signed [SAMPLE_WIDTH+1:0] offset_ext;
  logic signed [SAMPLE_WIDTH+26:0] summed_ext;
  logic signed [SAMPLE_WIDTH+26:0] gain_ext;
  logic signed [SAMPLE_WIDTH+26:0] product;
  logic signed [SAMPLE_WIDTH+3:0] scaled;
  localparam logic signed [SAMPLE_WIDTH-1:0] SAT_MAX = {1'b0, {(SAMPLE_WIDTH-1){1'b1}}};
  localparam logic signed [SAMPLE_WIDTH-1:0] SAT_MIN = {1'b1, {(SAMPLE_WIDTH-1){1'b0}}};

  always_comb begin
    sample_ext = (SAMPLE_WIDTH+2)'(sample_in);
    offset_ext = (SAMPLE_WIDTH+2)'(offset_cal_out);
    summed = sample_ext + offset_ext;
    summed_ext = (SAMPLE_WIDTH+27)'(summed);
    gain_ext = (SAMPLE_WIDTH+27)'($signed({1'b0, gain_cal_out}));
    product = summed_ext * gain_ext;
    scaled = product[SAMPLE_WIDTH+26:cccr_pkg::CCCR_GAIN_FRAC];
    if (scaled > $signed({4'h0, SAT_MAX}))
      res_next = SAT_MAX;
    else if (scaled < $signed({4'hf, SAT_MIN}))
      res_next = SAT_MIN;
    else
      res_next = scaled[SAMPLE_WIDTH-1:0];
    if (!sample_valid_in)
      res_next = res_reg;
    vld_next = sample_valid_in;
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      res_reg <= '0;
      vld_reg <= 1'b0;
    end else begin
      res_reg <= res_next;
      vld_reg <= vld_next;
    end
  end

  assign sample_out = res_reg;
  assign sample_valid_out = vld_reg;
  // ==========================================================
  // checks
  property p_cfg_reserved;
    @(posedge clock_in) disable iff (!reset_n_in)
      cfg_reg[cccr_pkg::CCCR_RSV_MSB:cccr_pkg::CCCR_RSV_LSB] == 3'h0;
  endproperty
  a_cfg_reserved: assert property (p_cfg_reserved) else $error("config reserved bits set");
  property p_cfg_write;
    @(posedge clock_in) disable iff (!reset_n_in)
      (wr_pend_reg && wr_idx_reg == cccr_pkg::CCCR_IDX_CONFIG)
      |=> dc_filter_bypass_out == $past(hwdata_in[2]);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("bypass bit not written");
  property p_sel_write;
    @(posedge clock_in) disable iff (!reset_n_in)
      (wr_pend_reg && wr_idx_reg == cccr_pkg::CCCR_IDX_CONFIG)
      |=> input_source_select_out == $past(hwdata_in[1:0]);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("selector not written");
  property p_cfg_read;
    @(posedge clock_in) disable iff (!reset_n_in)
      (addr_ok && !hwrite_in && addr_idx == cccr_pkg::CCCR_IDX_CONFIG && !wr_pend_reg)
      |=> hrdata_out == {16'h0000, $past(cfg_reg)};
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("config read mismatch");
  property p_ofs_hi;
    @(posedge clock_in) disable iff (!reset_n_in)
      (wr_pend_reg && wr_idx_reg == cccr_pkg::CCCR_IDX_OFS_HI)
      |=> offset_cal_out[23:8] == $past(hwdata_in[15:0]);
  endproperty
  a_ofs_hi: assert property (p_ofs_hi) else $error("offset high not written");
  property p_ofs_lo;
    @(posedge clock_in) disable iff (!reset_n_in) ofs_lo_reg[7:0] == 8'h00;
  endproperty
  a_ofs_lo: assert property (p_ofs_lo) else $error("offset low reserved set");
  property p_gain_hi;
    @(posedge clock_in) disable iff (!reset_n_in)
      (wr_pend_reg && wr_idx_reg == cccr_pkg::CCCR_IDX_GAIN_HI)
      |=> gain_cal_out[23:8] == $past(hwdata_in[15:0]);
  endproperty
  a_gain_hi: assert property (p_gain_hi) else $error("gain high not written");
  property p_gain_lo;
    @(posedge clock_in) disable iff (!reset_n_in) gain_lo_reg[7:0] == 8'h00;
  endproperty
  a_gain_lo: assert property (p_gain_lo) else $error("gain low reserved set");
  property p_gain_hold;
    @(posedge clock_in) disable iff (!reset_n_in)
      !(wr_pend_reg && wr_idx_reg == cccr_pkg::CCCR_IDX_GAIN_HI) |=> $stable(gain_hi_reg);
  endproperty
  a_gain_hold: assert property (p_gain_hold) else $error("gain high changed");
  property p_sample_vld;
    @(posedge clock_in) disable iff (!reset_n_in)
      sample_valid_in |=> sample_valid_out ##0 ($past(gain_cal_out) != 24'h800000
      || $past(offset_cal_out) != 24'h0 || sample_out == $past(sample_in));
  endproperty
  a_sample_vld: assert property (p_sample_vld) else $error("unity pass-through wrong");
  // ==========================================================
  // reset value checks
  property p_cfg_rst;
    @(posedge clock_in) !reset_n_in |=> cfg_reg == cccr_pkg::CCCR_RST_CONFIG;
  endproperty
  a_cfg_rst: assert property (p_cfg_rst) else $error("config reset wrong");
  property p_ofs_rst;
    @(posedge clock_in) !reset_n_in |=> ofs_hi_reg == cccr_pkg::CCCR_RST_OFS_HI;
  endproperty
  a_ofs_rst: assert property (p_ofs_rst) else $error("offset high reset wrong");
  property p_ofs_lo_rst;
    @(posedge clock_in) !reset_n_in |=> ofs_lo_reg == cccr_pkg::CCCR_RST_OFS_LO;
  endproperty
  a_ofs_lo_rst: assert property (p_ofs_lo_rst) else $error("offset low reset wrong");
  property p_gain_rst;
    @(posedge clock_in) !reset_n_in |=> gain_hi_reg == cccr_pkg::CCCR_RST_GAIN_HI;
  endproperty
  a_gain_rst: assert property (p_gain_rst) else $error("gain high reset wrong");
  property p_gain_lo_rst;
    @(posedge clock_in) !reset_n_in |=> gain_lo_reg == cccr_pkg::CCCR_RST_GAIN_LO;
  endproperty
  a_gain_lo_rst: assert property (p_gain_lo_rst) else $error("gain low reset wrong");
  // ==========================================================
  // write and hold checks
  property p_phase_write;
    @(posedge clock_in) disable iff (!reset_n_in)
      (wr_pend_reg && wr_idx_reg == cccr_pkg::CCCR_IDX_CONFIG)
      |=> phase_delay_field_out ==
        $past(hwdata_in[cccr_pkg::CCCR_PHASE_MSB:cccr_pkg::CCCR_PHASE_LSB]);
  endproperty
  a_phase_write: assert property (p_phase_write) else $error("phase not written");
  property p_ofs_lo_write;
    @(posedge clock_in) disable iff (!reset_n_in)
      (wr_pend_reg && wr_idx_reg == cccr_pkg::CCCR_IDX_OFS_LO)
      |=> offset_cal_out == {$past(ofs_hi_reg),
        $past(hwdata_in[cccr_pkg::CCCR_LOW_MSB:cccr_pkg::CCCR_LOW_LSB])};
  endproperty
  a_ofs_lo_write: assert property (p_ofs_lo_write) else $error("offset low not written");
  property p_gain_lo_write;
    @(posedge clock_in) disable iff (!reset_n_in)
      (wr_pend_reg && wr_idx_reg == cccr_pkg::CCCR_IDX_GAIN_LO)
      |=> gain_cal_out == {$past(gain_hi_reg),
        $past(hwdata_in[cccr_pkg::CCCR_LOW_MSB:cccr_pkg::CCCR_LOW_LSB])};
  endproperty
  a_gain_lo_write: assert property (p_gain_lo_write) else $error("gain low not written");
  property p_cfg_hold;
    @(posedge clock_in) disable iff (!reset_n_in)
      !(wr_pend_reg && wr_idx_reg == cccr_pkg::CCCR_IDX_CONFIG) |=> $stable(cfg_reg);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config changed without write");
  property p_ofs_hold;
    @(posedge clock_in) disable iff (!reset_n_in)
      !(wr_pend_reg && (wr_idx_reg == cccr_pkg::CCCR_IDX_OFS_HI
      || wr_idx_reg == cccr_pkg::CCCR_IDX_OFS_LO)) |=> $stable(offset_cal_out);
  endproperty
  a_ofs_hold: assert property (p_ofs_hold) else $error("offset changed without write");
  property p_gain_lo_hold;
    @(posedge clock_in) disable iff (!reset_n_in)
      !(wr_pend_reg && wr_idx_reg == cccr_pkg::CCCR_IDX_GAIN_LO) |=> $stable(gain_lo_reg);
  endproperty
  a_gain_lo_hold: assert property (p_gain_lo_hold) else $error("gain low changed");
  // ==========================================================
  // read-back checks
  property p_cfg_rd_rsv;
    @(posedge clock_in) disable iff (!reset_n_in)
      (addr_ok && !hwrite_in && addr_idx == cccr_pkg::CCCR_IDX_CONFIG)
      |=> hrdata_out[cccr_pkg::CCCR_RSV_MSB:cccr_pkg::CCCR_RSV_LSB] == 3'h0;
  endproperty
  a_cfg_rd_rsv: assert property (p_cfg_rd_rsv) else $error("config reserved read set");
  property p_ofs_lo_rd;
    @(posedge clock_in) disable iff (!reset_n_in)
      (addr_ok && !hwrite_in && addr_idx == cccr_pkg::CCCR_IDX_OFS_LO)
      |=> hrdata_out[cccr_pkg::CCCR_LOW_LSB-1:0] == 8'h00;
  endproperty
  a_ofs_lo_rd: assert property (p_ofs_lo_rd) else $error("offset low reserved read set");
  property p_gain_lo_rd;
    @(posedge clock_in) disable iff (!reset_n_in)
      (addr_ok && !hwrite_in && addr_idx == cccr_pkg::CCCR_IDX_GAIN_LO)
      |=> hrdata_out[cccr_pkg::CCCR_LOW_LSB-1:0] == 8'h00;
  endproperty
  a_gain_lo_rd: assert property (p_gain_lo_rd) else $error("gain low reserved read set");
  // ==========================================================
  // datapath checks
  property p_vld_idle;
    @(posedge clock_in) disable iff (!reset_n_in)
      !sample_valid_in |=> !sample_valid_out && $stable(sample_out);
  endproperty
  a_vld_idle: assert property (p_vld_idle) else $error("result changed without sample");
  property p_no_wrap;
    @(posedge clock_in) disable iff (!reset_n_in)
      (sample_valid_in && !sample_in[SAMPLE_WIDTH-1] && !offset_cal_out[23])
      |=> !sample_out[SAMPLE_WIDTH-1];
  endproperty
  a_no_wrap: assert property (p_no_wrap) else $error("positive result wrapped negative");
endmodule
`default_nettype wire

/* File: testbench/test_cccr_regs.sv */
/*
  self-checking bench for the channel configuration and calibration bank.
  assumes the bus slave answers with hreadyout and the datapath answers in one cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module test_cccr_regs;
  // ==========================================================
  // signals and instance
  logic clock_in, reset_n_in, hsel_in, hwrite_in, sample_valid_in;
  logic [31:0] haddr_in, hwdata_in, hrdata_out;
  logic [1:0] htrans_in, input_source_select_out;
  logic [2:0] hsize_in;
  logic hreadyout_out, hresp_out, sample_valid_out, dc_filter_bypass_out;
  logic signed [23:0] sample_in, sample_out, offset_cal_out;
  logic signed [9:0] phase_delay_field_out;
  logic [23:0] gain_cal_out;
  logic [15:0] v;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  cccr_regs dut_u (.clock_in(clock_in), .reset_n_in(reset_n_in), .hsel_in(hsel_in),
    .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in),
    .hwdata_in(hwdata_in), .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .sample_in(sample_in),
    .sample_valid_in(sample_valid_in), .sample_out(sample_out),
    .sample_valid_out(sample_valid_out), .phase_delay_field_out(phase_delay_field_out),
    .dc_filter_bypass_out(dc_filter_bypass_out),
    .input_source_select_out(input_source_select_out), .offset_cal_out(offset_cal_out),
    .gain_cal_out(gain_cal_out));
  // ==========================================================
  // clock, timeout, verdict
  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end
  task automatic print_verdict();
    if (miscompares == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      print_verdict();
    end
  end
  // ==========================================================
  // compare and bus tasks
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [2:0] sz,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clock_in);
    hsel_in <= 1'b1;
    haddr_in <= {22'h0, idx, 2'h0};
    htrans_in <= cccr_pkg::CCCR_HTRANS_NONSEQ;
    hwrite_in <= wr;
    hsize_in <= sz;
    @(posedge clock_in);
    while (hreadyout_out !== 1'b1) @(posedge clock_in);
    htrans_in <= 2'h0;
    hsel_in <= 1'b0;
    hwdata_in <= wd;
    @(posedge clock_in);
    while (hreadyout_out !== 1'b1) @(posedge clock_in);
    rd = hrdata_out;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [15:0] d, input logic [2:0] sz = 3'h2);
    logic [31:0] unused;
    bus(1'b1, idx, sz, {16'h0, d}, unused);
  endtask
  task automatic rd_chk(input string name, input logic [7:0] idx, input logic [15:0] e);
    logic [31:0] r;
    bus(1'b0, idx, 3'h2, 32'h0, r);
    chk(name, {16'h0, e}, r);
    chk({name, "_resp"}, 32'h0, {31'h0, hresp_out});
  endtask
  task automatic sample(input logic [23:0] s, input logic [23:0] e);
    @(posedge clock_in);
    sample_in <= s;
    sample_valid_in <= 1'b1;
    @(posedge clock_in);
    sample_valid_in <= 1'b0;
    @(negedge clock_in);
    chk("valid_out", 32'h1, {31'h0, sample_valid_out});
    chk("sample_out", {8'h0, e}, {8'h0, sample_out});
    @(negedge clock_in);
    chk("valid_fall", 32'h0, {31'h0, sample_valid_out});
    chk("sample_hold", {8'h0, e}, {8'h0, sample_out});
  endtask
  // ==========================================================
  // main sequence
  initial begin
    {reset_n_in, hsel_in, hwrite_in, sample_valid_in, htrans_in} = '0;
    {haddr_in, hwdata_in, sample_in, hsize_in} = '0;
    repeat (10) @(posedge clock_in);
    reset_n_in <= 1'b1;
    @(negedge clock_in);
    chk("gain_cal", 32'h800000, {8'h0, gain_cal_out});
    rd_chk("config", cccr_pkg::CCCR_IDX_CONFIG, 16'h0000);
    rd_chk("ofs_hi", cccr_pkg::CCCR_IDX_OFS_HI, 16'h0000);
    rd_chk("ofs_lo", cccr_pkg::CCCR_IDX_OFS_LO, 16'h0000);
    rd_chk("gain_hi", cccr_pkg::CCCR_IDX_GAIN_HI, 16'h8000);
    rd_chk("gain_lo", cccr_pkg::CCCR_IDX_GAIN_LO, 16'h0000);
    sample(24'h123456, 24'h123456);
    for (int i = 0; i < 4; i++) begin
      v = {10'h200 ^ 10'(i), 3'h7, 1'(i), 2'(i)};
      wr(cccr_pkg::CCCR_IDX_CONFIG, v);
      @(negedge clock_in);
      chk("phase", {22'h0, 10'h200 ^ 10'(i)}, {22'h0, phase_delay_field_out});
      chk("bypass", {31'h0, 1'(i)}, {31'h0, dc_filter_bypass_out});
      chk("select", {30'h0, 2'(i)}, {30'h0, input_source_select_out});
      rd_chk("config", cccr_pkg::CCCR_IDX_CONFIG, v & 16'hffc7);
    end
    wr(cccr_pkg::CCCR_IDX_CONFIG, 16'h0000, 3'h1);
    rd_chk("config_half", cccr_pkg::CCCR_IDX_CONFIG, v & 16'hffc7);
    wr(cccr_pkg::CCCR_IDX_OFS_HI, 16'h8001);
    wr(cccr_pkg::CCCR_IDX_OFS_LO, 16'hffff);
    rd_chk("ofs_lo", cccr_pkg::CCCR_IDX_OFS_LO, 16'hff00);
    rd_chk("ofs_hi", cccr_pkg::CCCR_IDX_OFS_HI, 16'h8001);
    chk("offset_cal", 32'h8001ff, {8'h0, offset_cal_out});
    wr(cccr_pkg::CCCR_IDX_GAIN_HI, 16'hffff);
    wr(cccr_pkg::CCCR_IDX_GAIN_LO, 16'hffff);
    rd_chk("gain_lo", cccr_pkg::CCCR_IDX_GAIN_LO, 16'hff00);
    rd_chk("gain_hi", cccr_pkg::CCCR_IDX_GAIN_HI, 16'hffff);
    chk("gain_cal", 32'hffffff, {8'h0, gain_cal_out});
    wr(8'h13, 16'hffff);
    rd_chk("unmapped", 8'h13, 16'h0000);
    rd_chk("gain_hi", cccr_pkg::CCCR_IDX_GAIN_HI, 16'hffff);
    wr(cccr_pkg::CCCR_IDX_OFS_HI, 16'h0000);
    wr(cccr_pkg::CCCR_IDX_OFS_LO, 16'h1000);
    wr(cccr_pkg::CCCR_IDX_GAIN_HI, 16'h4000);
    wr(cccr_pkg::CCCR_IDX_GAIN_LO, 16'h0000);
    sample(24'd100, 24'd58);
    sample(-24'sd100, -24'sd42);
    wr(cccr_pkg::CCCR_IDX_GAIN_HI, 16'hffff);
    sample(24'h7ffff0, 24'h7fffff);
    sample(24'h800000, 24'h800000);
    print_verdict();
  end
endmodule
`default_nettype wire
